/* File: hdl/oscd_consts.vh */
// constants for the output switch counter and status display block
`ifndef OSCD_CONSTS_VH
`define OSCD_CONSTS_VH
// register byte offsets
`define OSCD_REG_CTRL 12'h000
`define OSCD_REG_THR1 12'h004
`define OSCD_REG_THR2 12'h008
`define OSCD_REG_CNT1 12'h00C
`define OSCD_REG_CNT2 12'h010
`define OSCD_REG_RST 12'h014
`define OSCD_REG_IRQ_STAT 12'h018
`define OSCD_REG_IRQ_MASK 12'h01C
`define OSCD_REG_STATUS 12'h020
// ctrl fields
`define OSCD_CTRL_LIN1 0
`define OSCD_CTRL_LIN2 1
`define OSCD_CTRL_PSEL_LO 4
`define OSCD_CTRL_SSEL_LO 8
`define OSCD_CTRL_HEATER_EN 12
`define OSCD_CTRL_RESET 32'h0000_1000
// counter limits
`define OSCD_CNT_MAX 14'h270F
`define OSCD_PRE_MAX 7'h63
// status selector codes
`define OSCD_SEL_OFF 3'h0
`define OSCD_SEL_MANUAL 3'h1
`define OSCD_SEL_STOP 3'h2
`define OSCD_SEL_FIRST_ALARM_SYMBOL 3'h3
`define OSCD_SEL_SECOND_ALARM_SYMBOL 3'h4
`define OSCD_SEL_THIRD_ALARM_SYMBOL 3'h5
`define OSCD_SEL_ALMOR 3'h6
`define OSCD_SEL_HEATER 3'h7
// secondary display sources
`define OSCD_SD_NORMAL 3'h0
`define OSCD_SD_STATUS 3'h1
`define OSCD_SD_PROGEND 3'h2
`define OSCD_SD_AUTOTUNE 3'h3
`define OSCD_SD_CNTALM 3'h4
`define OSCD_SD_RANGE 3'h5
// display symbol codes
`define OSCD_SYM_NONE 4'h0
`define OSCD_SYM_MANUAL 4'h1
`define OSCD_SYM_STOP 4'h2
`define OSCD_SYM_FIRST_ALARM_SYMBOL 4'h3
`define OSCD_SYM_SECOND_ALARM_SYMBOL 4'h4
`define OSCD_SYM_THIRD_ALARM_SYMBOL 4'h5
`define OSCD_SYM_ANY 4'h6
`define OSCD_SYM_HEATER 4'h7
`define OSCD_SYM_CNTALM 4'h8
// timing
`define OSCD_ALT_HALF_NS 500000000
`define OSCD_CLK_NS 4
`define OSCD_KEY_WAIT_NS 2000000000
`define OSCD_ACCESS_CODE 16'hFF57
`endif

/* File: hdl/oscd_top.v */
// output switch counter, count alarm and front-panel status alternation
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
// What this block does
// - count each control output separately, only when it is on/off type
// - a zero threshold stops counting for that output; zero is default
// - monitor value spans 0..9999 in hundreds of operations, resets to zero
// - threshold 0..9999; alarm while counter exceeds a nonzero threshold
// - count alarm on COUNT_ALARM_ROUTE as the OR of both output alarms, and shown on display
// - reset selector 0 none, 1 clears counter one, 2 clears counter two
// - after a counter reset the monitor value returns to zero
// - corrupted counter data forces 9999 and alarm until counter reset
// - active count alarm alternates its symbol on the secondary display
// - hide monitor items when both thresholds zero or outputs linear
// - primary display alternates value and status symbol every half second
// - primary selector: off, manual, stop, alarms 1-3, their OR, heater
// - secondary selector same choices, alternates its value with symbol
// - heater choice true on burnout, short or overcurrent; inert without detection
// - combined alarm choice true whenever alarm 1, 2 or 3 is on
// - secondary priority: status, program end, autotune, count alarm, range
// - advanced level needs code -169, then key press or two idle seconds
`include "oscd_consts.vh"
module oscd_top #(
    parameter [31:0] ALT_HALF_CYC = `OSCD_ALT_HALF_NS / `OSCD_CLK_NS,
    parameter [31:0] KEY_WAIT_CYC = `OSCD_KEY_WAIT_NS / `OSCD_CLK_NS
) (
    input wire SYS_CLK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire CTRL_OUT1_PIN,
    input wire CTRL_OUT2_PIN,
    input wire MANUAL_PIN,
    input wire STOPPED_PIN,
    input wire ALARM1_PIN,
    input wire ALARM2_PIN,
    input wire ALARM3_PIN,
    input wire HEATER_BURNOUT_PIN,
    input wire HEATER_SHORT_PIN,
    input wire HEATER_OVERCURRENT_PIN,
    input wire PROGRAM_END_PIN,
    input wire AUTOTUNE_PIN,
    input wire OUT_OF_RANGE_PIN,
    input wire KEY_CONFIRM_PIN,
    input wire KEY_ACTIVITY_PIN,
    input wire CNT1_CORRUPT,
    input wire CNT2_CORRUPT,
    input wire [15:0] ACCESS_CODE_IN,
    input wire ACCESS_CODE_VALID,
    output reg COUNT_ALARM1,
    output reg COUNT_ALARM2,
    output reg COUNT_ALARM_ROUTE,
    output reg MONITOR_VISIBLE,
    output reg PRIMARY_SHOW_SYMBOL,
    output reg [3:0] PRIMARY_SYMBOL,
    output reg [2:0] SECONDARY_SOURCE,
    output reg [3:0] SECONDARY_SYMBOL,
    output reg SECONDARY_BLANK,
    output reg ADVANCED_LEVEL,
    output reg IRQ
);

    // software registers
    reg [31:0] ctrl_q;
    reg [13:0] thr_q [0:1];
    reg [13:0] cnt_q [0:1];
    reg [6:0] pre_q [0:1];
    reg [1:0] bad_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    reg [31:0] rdata_d;
    reg addr_ok;
    // sync chains: first stage feeds only the second
    wire [14:0] pin_raw;
    reg [14:0] pin_s1_q;
    reg [14:0] pin_s2_q;
    reg [1:0] out_prev_q;
    // display timing
    reg [31:0] alt_cnt_q;
    reg alt_phase_q;
    reg [31:0] wait_cnt_q;
    reg code_ok_q;
    // derived conditions
    wire wr_en;
    wire rd_en;
    wire [1:0] cnt_reset;
    wire [1:0] alarm;
    wire any_alarm;
    wire heater_any;
    wire [3:0] irq_ev;
    wire prim_cond;
    wire sec_cond;
    wire [3:0] prim_sym;
    wire [3:0] sec_sym;
    genvar gi;

    assign pin_raw = {KEY_ACTIVITY_PIN, KEY_CONFIRM_PIN, OUT_OF_RANGE_PIN, AUTOTUNE_PIN, PROGRAM_END_PIN,
                      HEATER_OVERCURRENT_PIN, HEATER_SHORT_PIN, HEATER_BURNOUT_PIN, ALARM3_PIN, ALARM2_PIN,
                      ALARM1_PIN, STOPPED_PIN, MANUAL_PIN, CTRL_OUT2_PIN, CTRL_OUT1_PIN};
    assign wr_en = PSEL & PENABLE & PWRITE & PREADY;
    assign rd_en = PSEL & ~PENABLE & ~PWRITE;
    // writing the reset register with 1 or 2 clears the matching counter
    assign cnt_reset[0] = wr_en & (PADDR == `OSCD_REG_RST) & (PWDATA[1:0] == 2'h1);
    assign cnt_reset[1] = wr_en & (PADDR == `OSCD_REG_RST) & (PWDATA[1:0] == 2'h2);
    assign heater_any = ctrl_q[`OSCD_CTRL_HEATER_EN] &
                        (pin_s2_q[7] | pin_s2_q[8] | pin_s2_q[9]);
    assign any_alarm = pin_s2_q[4] | pin_s2_q[5] | pin_s2_q[6];

    // two-stage synchronisers on all pin inputs
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pin_s1_q <= 15'h0000;
            pin_s2_q <= 15'h0000;
            out_prev_q <= 2'h0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            out_prev_q <= pin_s2_q[1:0];
        end
    end

    // per-output counter; one switching operation is a completed on-then-off cycle
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_cnt
            wire off_edge;
            wire count_en;
            wire corrupt;
            assign off_edge = out_prev_q[gi] & ~pin_s2_q[gi];
            assign count_en = ~ctrl_q[`OSCD_CTRL_LIN1 + gi] & (thr_q[gi] != 14'h0000);
            assign corrupt = (gi == 0) ? CNT1_CORRUPT : CNT2_CORRUPT;
            assign alarm[gi] = bad_q[gi] | ((thr_q[gi] != 14'h0000) & (cnt_q[gi] > thr_q[gi]));
            always @(posedge SYS_CLK) begin
                if (!RST_N) begin
                    cnt_q[gi] <= 14'h0000;
                    pre_q[gi] <= 7'h00;
                    bad_q[gi] <= 1'b0;
                end else if (cnt_reset[gi]) begin
                    cnt_q[gi] <= 14'h0000;
                    pre_q[gi] <= 7'h00;
                    bad_q[gi] <= 1'b0;
                end else if (corrupt || cnt_q[gi] > `OSCD_CNT_MAX) begin
                    // bad data sticks at full scale until software resets this counter
                    cnt_q[gi] <= `OSCD_CNT_MAX;
                    bad_q[gi] <= 1'b1;
                end else if (count_en && off_edge && !bad_q[gi]) begin
                    if (pre_q[gi] == `OSCD_PRE_MAX) begin
                        pre_q[gi] <= 7'h00;
                        if (cnt_q[gi] != `OSCD_CNT_MAX) begin
                            cnt_q[gi] <= cnt_q[gi] + 14'h0001;
                        end
                    end else begin
                        pre_q[gi] <= pre_q[gi] + 7'h01;
                    end
                end
            end
        end
    endgenerate

    // status symbol decode shared by both selectors
    function [4:0] oscd_status;
        input [2:0] sel;
        input [14:0] p;
        input any_a;
        input heat;
        begin
            case (sel)
                `OSCD_SEL_MANUAL: oscd_status = {p[2], `OSCD_SYM_MANUAL};
                `OSCD_SEL_STOP: oscd_status = {p[3], `OSCD_SYM_STOP};
                `OSCD_SEL_FIRST_ALARM_SYMBOL: oscd_status = {p[4], `OSCD_SYM_FIRST_ALARM_SYMBOL};
                `OSCD_SEL_SECOND_ALARM_SYMBOL: oscd_status = {p[5], `OSCD_SYM_SECOND_ALARM_SYMBOL};
                `OSCD_SEL_THIRD_ALARM_SYMBOL: oscd_status = {p[6], `OSCD_SYM_THIRD_ALARM_SYMBOL};
                `OSCD_SEL_ALMOR: oscd_status = {any_a, `OSCD_SYM_ANY};
                `OSCD_SEL_HEATER: oscd_status = {heat, `OSCD_SYM_HEATER};
                default: oscd_status = {1'b0, `OSCD_SYM_NONE};
            endcase
        end
    endfunction

    // synced pin vector goes in unshifted: bit 2 manual, 3 stopped, 4..6 alarms one to three
    assign {prim_cond, prim_sym} = oscd_status(ctrl_q[`OSCD_CTRL_PSEL_LO +: 3], pin_s2_q,
                                               any_alarm, heater_any);
    assign {sec_cond, sec_sym} = oscd_status(ctrl_q[`OSCD_CTRL_SSEL_LO +: 3], pin_s2_q,
                                             any_alarm, heater_any);

    // half-second alternation phase, one free-running divider for both displays
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            alt_cnt_q <= 32'h0000_0000;
            alt_phase_q <= 1'b0;
        end else if (alt_cnt_q >= ALT_HALF_CYC - 32'h0000_0001) begin
            alt_cnt_q <= 32'h0000_0000;
            alt_phase_q <= ~alt_phase_q;
        end else begin
            alt_cnt_q <= alt_cnt_q + 32'h0000_0001;
        end
    end

    // display outputs; secondary picks the highest-priority active indication
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PRIMARY_SHOW_SYMBOL <= 1'b0;
            PRIMARY_SYMBOL <= `OSCD_SYM_NONE;
            SECONDARY_SOURCE <= `OSCD_SD_NORMAL;
            SECONDARY_SYMBOL <= `OSCD_SYM_NONE;
            SECONDARY_BLANK <= 1'b0;
            COUNT_ALARM1 <= 1'b0;
            COUNT_ALARM2 <= 1'b0;
            COUNT_ALARM_ROUTE <= 1'b0;
            MONITOR_VISIBLE <= 1'b0;
        end else begin
            PRIMARY_SHOW_SYMBOL <= prim_cond & alt_phase_q;
            PRIMARY_SYMBOL <= prim_cond ? prim_sym : `OSCD_SYM_NONE;
            COUNT_ALARM1 <= alarm[0];
            COUNT_ALARM2 <= alarm[1];
            COUNT_ALARM_ROUTE <= alarm[0] | alarm[1];
            MONITOR_VISIBLE <= ~(((thr_q[0] == 14'h0000) & (thr_q[1] == 14'h0000)) |
                                 (ctrl_q[`OSCD_CTRL_LIN1] & ctrl_q[`OSCD_CTRL_LIN2]));
            if (sec_cond) begin
                SECONDARY_SOURCE <= `OSCD_SD_STATUS;
                SECONDARY_SYMBOL <= sec_sym;
                SECONDARY_BLANK <= alt_phase_q;
            end else if (pin_s2_q[10]) begin
                SECONDARY_SOURCE <= `OSCD_SD_PROGEND;
                SECONDARY_SYMBOL <= `OSCD_SYM_NONE;
                SECONDARY_BLANK <= alt_phase_q;
            end else if (pin_s2_q[11]) begin
                SECONDARY_SOURCE <= `OSCD_SD_AUTOTUNE;
                SECONDARY_SYMBOL <= `OSCD_SYM_NONE;
                SECONDARY_BLANK <= alt_phase_q;
            end else if (alarm[0] | alarm[1]) begin
                SECONDARY_SOURCE <= `OSCD_SD_CNTALM;
                SECONDARY_SYMBOL <= `OSCD_SYM_CNTALM;
                SECONDARY_BLANK <= alt_phase_q;
            end else if (pin_s2_q[12]) begin
                SECONDARY_SOURCE <= `OSCD_SD_RANGE;
                SECONDARY_SYMBOL <= `OSCD_SYM_NONE;
                SECONDARY_BLANK <= alt_phase_q;
            end else begin
                SECONDARY_SOURCE <= `OSCD_SD_NORMAL;
                SECONDARY_SYMBOL <= `OSCD_SYM_NONE;
                SECONDARY_BLANK <= 1'b0;
            end
        end
    end

    // advanced-level entry: code match, then confirm key or two idle seconds
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            code_ok_q <= 1'b0;
            wait_cnt_q <= 32'h0000_0000;
            ADVANCED_LEVEL <= 1'b0;
        end else if (ACCESS_CODE_VALID) begin
            code_ok_q <= (ACCESS_CODE_IN == `OSCD_ACCESS_CODE);
            wait_cnt_q <= 32'h0000_0000;
            ADVANCED_LEVEL <= 1'b0;
        end else if (code_ok_q) begin
            if (pin_s2_q[13] || wait_cnt_q >= KEY_WAIT_CYC - 32'h0000_0001) begin
                ADVANCED_LEVEL <= 1'b1;
                code_ok_q <= 1'b0;
            end else if (pin_s2_q[14]) begin
                wait_cnt_q <= 32'h0000_0000; // any other key restarts the idle wait
            end else begin
                wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
            end
        end
    end

    // interrupt events: count alarm rise per output, corruption per output
    assign irq_ev = {bad_q[1] & ~COUNT_ALARM2, bad_q[0] & ~COUNT_ALARM1,
                     alarm[1] & ~COUNT_ALARM2, alarm[0] & ~COUNT_ALARM1};

    // register writes; a new event beats a write-one clear in the same cycle
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl_q <= `OSCD_CTRL_RESET;
            thr_q[0] <= 14'h0000;
            thr_q[1] <= 14'h0000;
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr_en && PADDR == `OSCD_REG_IRQ_STAT) ? PWDATA[3:0] : 4'h0)) | irq_ev;
            if (wr_en) begin
                case (PADDR)
                    `OSCD_REG_CTRL: ctrl_q <= PWDATA & 32'h0000_1773;
                    `OSCD_REG_THR1: thr_q[0] <= (PWDATA[13:0] > `OSCD_CNT_MAX) ? `OSCD_CNT_MAX : PWDATA[13:0];
                    `OSCD_REG_THR2: thr_q[1] <= (PWDATA[13:0] > `OSCD_CNT_MAX) ? `OSCD_CNT_MAX : PWDATA[13:0];
                    `OSCD_REG_IRQ_MASK: irq_mask_q <= PWDATA[3:0];
                    default: irq_mask_q <= irq_mask_q;
                endcase
            end
        end
    end

    // read mux
    always @* begin
        addr_ok = 1'b1;
        case (PADDR)
            `OSCD_REG_CTRL: rdata_d = ctrl_q;
            `OSCD_REG_THR1: rdata_d = {18'h00000, thr_q[0]};
            `OSCD_REG_THR2: rdata_d = {18'h00000, thr_q[1]};
            `OSCD_REG_CNT1: rdata_d = {18'h00000, cnt_q[0]};
            `OSCD_REG_CNT2: rdata_d = {18'h00000, cnt_q[1]};
            `OSCD_REG_RST: rdata_d = 32'h0000_0000; // selector reads back as zero, its default
            `OSCD_REG_IRQ_STAT: rdata_d = {28'h0000000, irq_stat_q};
            `OSCD_REG_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
            `OSCD_REG_STATUS: rdata_d = {27'h0000000, ADVANCED_LEVEL, MONITOR_VISIBLE, bad_q, alarm[1] | alarm[0]};
            default: begin
                rdata_d = 32'h0000_0000;
                addr_ok = 1'b0;
            end
        endcase
    end

    // apb slave: one wait state, ready in the second access cycle
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_q & irq_mask_q);
            PREADY <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
            if (rd_en) begin
                PRDATA <= rdata_d;
            end
        end
    end

endmodule // oscd_top

/* File: verif/oscd_top_monitor.sv */
// port checker for the switch counter and status display block
`timescale 1ns/1ps
`include "oscd_consts.vh"
module oscd_top_monitor #(
    parameter [31:0] ALT_HALF_CYC = 32'h8,
    parameter [31:0] KEY_WAIT_CYC = 32'h10
) (
    input wire SYS_CLK,
    input wire RST_N,
    input wire CNT1_CORRUPT,
    input wire CNT2_CORRUPT,
    input wire [15:0] ACCESS_CODE_IN,
    input wire ACCESS_CODE_VALID,
    input wire COUNT_ALARM1,
    input wire COUNT_ALARM2,
    input wire COUNT_ALARM_ROUTE,
    input wire PRIMARY_SHOW_SYMBOL,
    input wire [3:0] PRIMARY_SYMBOL,
    input wire [2:0] SECONDARY_SOURCE,
    input wire [3:0] SECONDARY_SYMBOL,
    input wire ADVANCED_LEVEL
);
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    wire any_alm = COUNT_ALARM1 | COUNT_ALARM2;
    reg code_seen_q;
    // remembers a correct code since reset; level entry without one is a fault
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            code_seen_q <= 1'b0;
        end else if (ACCESS_CODE_VALID && ACCESS_CODE_IN == `OSCD_ACCESS_CODE) begin
            code_seen_q <= 1'b1;
        end
    end
    a_route_follows: assert property (any_alm |-> ##[0:2] COUNT_ALARM_ROUTE)
        else $error("alarm route output missing");
    a_route_quiet: assert property (!any_alm [*3] |-> !COUNT_ALARM_ROUTE)
        else $error("alarm route output without alarm");
    a_corrupt_one: assert property (CNT1_CORRUPT |-> ##[1:4] COUNT_ALARM1)
        else $error("corrupt counter one gave no alarm");
    a_corrupt_two: assert property (CNT2_CORRUPT |-> ##[1:4] COUNT_ALARM2)
        else $error("corrupt counter two gave no alarm");
    a_sec_alarm_cause: assert property (SECONDARY_SOURCE == `OSCD_SD_CNTALM |-> any_alm || $past(any_alm))
        else $error("count alarm shown without alarm");
    a_sec_alarm_sym: assert property (SECONDARY_SOURCE == `OSCD_SD_CNTALM |-> SECONDARY_SYMBOL == `OSCD_SYM_CNTALM)
        else $error("wrong symbol for count alarm");
    a_sec_priority: assert property (any_alm [*3] |-> SECONDARY_SOURCE != `OSCD_SD_NORMAL && SECONDARY_SOURCE != `OSCD_SD_RANGE)
        else $error("count alarm lost to lower indication");
    a_pri_symbol_set: assert property (PRIMARY_SHOW_SYMBOL |-> PRIMARY_SYMBOL != `OSCD_SYM_NONE)
        else $error("primary shows an empty symbol");
    a_pri_alt_bound: assert property (PRIMARY_SHOW_SYMBOL |-> ##[1:16] !PRIMARY_SHOW_SYMBOL)
        else $error("primary symbol phase never ends");
    a_adv_needs_code: assert property ($rose(ADVANCED_LEVEL) |-> code_seen_q)
        else $error("advanced level without access code");
endmodule // oscd_top_monitor
bind oscd_top oscd_top_monitor #(.ALT_HALF_CYC(ALT_HALF_CYC), .KEY_WAIT_CYC(KEY_WAIT_CYC)) u_mon (.*);

/* File: verif/oscd_panel_model.sv */
// front-panel model: access code entry and confirm key
`timescale 1ns/1ps
module oscd_panel_model (
    input wire clk,
    input wire go,
    input wire [15:0] code,
    input wire press,
    output reg key_confirm,
    output reg key_activity,
    output reg [15:0] code_out,
    output reg code_valid
);
    integer cnt = 0;
    initial begin
        key_confirm = 1'b0;
        key_activity = 1'b0;
        code_out = 16'h0000;
        code_valid = 1'b0;
    end
    // code valid one cycle only; afterwards the lines alternate between the inverted code and the code
    always @(posedge clk) begin
        code_valid <= go;
        code_out <= go ? code : ~code_out;
        cnt <= (go && press) ? 5 : ((cnt > 0) ? cnt - 1 : 0);
        key_confirm <= (cnt != 0);
        key_activity <= (cnt != 0);
    end
endmodule // oscd_panel_model

/* File: verif/tb.sv */
// self-checking bench for the switch counter and status display block
`timescale 1ns/1ps
`include "oscd_consts.vh"
module tb;
    localparam [31:0] KW = 32'h10;
    reg clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, o1 = 0, o2 = 0, c1 = 0, c2 = 0, go = 0, press = 0;
    reg [11:0] pa = 12'h000;
    reg [31:0] pwd = 32'h0, rdat = 32'h0;
    reg [10:0] p = 11'h000;
    reg [15:0] code = 16'h0000;
    reg [13:0] pr;
    reg err;
    wire [31:0] prdata;
    wire [15:0] co;
    wire [3:0] psym, ssym;
    wire [2:0] ssrc;
    wire pready, pslverr, kc, ka, cv, ca1, ca2, car, mv, pss, sb, adv, irq;
    integer err_count = 0, compares = 0, seed = 32'h18AEC83A, i, n, m;
    always #2 clk = ~clk;
    oscd_top #(.ALT_HALF_CYC(32'h8), .KEY_WAIT_CYC(KW)) u_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CTRL_OUT1_PIN(o1), .CTRL_OUT2_PIN(o2), .MANUAL_PIN(p[0]), .STOPPED_PIN(p[1]), .ALARM1_PIN(p[2]),
        .ALARM2_PIN(p[3]), .ALARM3_PIN(p[4]), .HEATER_BURNOUT_PIN(p[5]), .HEATER_SHORT_PIN(p[6]),
        .HEATER_OVERCURRENT_PIN(p[7]), .PROGRAM_END_PIN(p[8]), .AUTOTUNE_PIN(p[9]), .OUT_OF_RANGE_PIN(p[10]),
        .KEY_CONFIRM_PIN(kc), .KEY_ACTIVITY_PIN(ka), .CNT1_CORRUPT(c1), .CNT2_CORRUPT(c2), .ACCESS_CODE_IN(co),
        .ACCESS_CODE_VALID(cv), .COUNT_ALARM1(ca1), .COUNT_ALARM2(ca2), .COUNT_ALARM_ROUTE(car),
        .MONITOR_VISIBLE(mv), .PRIMARY_SHOW_SYMBOL(pss), .PRIMARY_SYMBOL(psym), .SECONDARY_SOURCE(ssrc),
        .SECONDARY_SYMBOL(ssym), .SECONDARY_BLANK(sb), .ADVANCED_LEVEL(adv), .IRQ(irq));
    oscd_panel_model u_panel (.clk(clk), .go(go), .code(code), .press(press), .key_confirm(kc),
        .key_activity(ka), .code_out(co), .code_valid(cv));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares = compares + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wt(input integer k);
        repeat (k) @(posedge clk);
    endtask
    // one transfer; the request stands until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(negedge clk);
            k = k + 1;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 20) err_count = err_count + 1;
    endtask
    task rchk(input string nm, input [11:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    // widths stay above the pin synchroniser depth so no edge is lost
    task pulses(input integer n1, input integer n2);
        integer j;
        for (j = 0; j < n1 || j < n2; j = j + 1) begin
            o1 <= (j < n1);
            o2 <= (j < n2);
            wt(3 + {$random(seed)} % 3);
            o1 <= 1'b0;
            o2 <= 1'b0;
            wt(3 + {$random(seed)} % 3);
        end
    endtask
    function [31:0] any_alarm_symbol(input integer cnt, input integer thr);
        any_alarm_symbol = (thr != 0 && cnt > thr);
    endfunction
    function [10:0] cond(input integer s);
        integer r;
        r = {$random(seed)} % 3;
        case (s)
            1, 2, 3, 4, 5: cond = 11'h001 << (s - 1);
            6: cond = 11'h004 << r;
            default: cond = 11'h020 << r;
        endcase
    endfunction
    function [13:0] prio(input integer k);
        case (k)
            0: prio = {11'h700, `OSCD_SD_PROGEND};
            1: prio = {11'h600, `OSCD_SD_AUTOTUNE};
            2: prio = {11'h400, `OSCD_SD_RANGE};
            default: prio = {11'h704, `OSCD_SD_STATUS};
        endcase
    endfunction
    // pins settle before sampling so a stale phase is not mistaken for a new one
    task sym(input [31:0] base, input [2:0] s, input [10:0] pv, input [3:0] e);
        logic [3:0] g;
        p <= pv;
        apb(1'b1, `OSCD_REG_CTRL, base | (s << 4) | (s << 8));
        wt(6);
        g = `OSCD_SYM_NONE;
        repeat (40) begin
            @(posedge clk);
            if (pss === 1'b1) g = psym;
        end
        chk("primary symbol", e, g);
        chk("secondary source", (e == 0) ? `OSCD_SD_NORMAL : `OSCD_SD_STATUS, ssrc);
        chk("secondary symbol", e, ssym);
    endtask
    task code_try(input [15:0] c, input k, input integer w, input e);
        code <= c;
        press <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wt(w);
        chk("advanced level", e, adv);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, several times the few thousand cycles the tests need
    initial begin
        #200000;
        err_count = err_count + 1;
        wrap_up;
    end
    initial begin
        wt(20);
        rst_n <= 1'b1;
        rchk("ctrl", `OSCD_REG_CTRL, `OSCD_CTRL_RESET);
        rchk("thr1", `OSCD_REG_THR1, 32'h0);
        rchk("cnt2", `OSCD_REG_CNT2, 32'h0);
        rchk("rst sel", `OSCD_REG_RST, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", 32'h1, err);
        chk("monitor hidden", 32'h0, mv);
        pulses(100, 0);
        rchk("cnt1 thr zero", `OSCD_REG_CNT1, 32'h0);
        apb(1'b1, `OSCD_REG_THR1, 32'h1);
        apb(1'b1, `OSCD_REG_CTRL, `OSCD_CTRL_RESET | 32'h1);
        pulses(100, 0);
        rchk("cnt1 linear", `OSCD_REG_CNT1, 32'h0);
        $display("gating test done");
        apb(1'b1, `OSCD_REG_CTRL, `OSCD_CTRL_RESET);
        apb(1'b1, `OSCD_REG_THR2, 32'h2);
        apb(1'b1, `OSCD_REG_IRQ_MASK, 32'h0);
        n = 200 + {$random(seed)} % 100;
        m = 100 + {$random(seed)} % 100;
        pulses(n, m);
        wt(8);
        rchk("cnt1", `OSCD_REG_CNT1, n / 100);
        rchk("cnt2", `OSCD_REG_CNT2, m / 100);
        chk("alarm1", any_alarm_symbol(n / 100, 1), ca1);
        chk("alarm2", any_alarm_symbol(m / 100, 2), ca2);
        chk("route", 32'h1, car);
        chk("sec count alarm", `OSCD_SD_CNTALM, ssrc);
        chk("monitor shown", 32'h1, mv);
        chk("irq masked", 32'h0, irq);
        rchk("irq stat", `OSCD_REG_IRQ_STAT, 32'h1);
        apb(1'b1, `OSCD_REG_IRQ_MASK, 32'h1);
        wt(2);
        chk("irq raised", 32'h1, irq);
        apb(1'b1, `OSCD_REG_IRQ_STAT, 32'h1);
        wt(2);
        chk("irq cleared", 32'h0, irq);
        $display("counting test done");
        apb(1'b1, `OSCD_REG_RST, 32'h0);
        rchk("rst none", `OSCD_REG_CNT1, n / 100);
        apb(1'b1, `OSCD_REG_RST, 32'h1);
        rchk("rst one", `OSCD_REG_CNT1, 32'h0);
        rchk("rst keeps two", `OSCD_REG_CNT2, m / 100);
        for (i = 1; i < 3; i = i + 1) begin
            c1 <= (i == 1);
            c2 <= (i == 2);
            wt(1);
            c1 <= 1'b0;
            c2 <= 1'b0;
            wt(20);
            rchk("cnt corrupt", (i == 1) ? `OSCD_REG_CNT1 : `OSCD_REG_CNT2, `OSCD_CNT_MAX);
            chk("alarm latched", 32'h1, (i == 1) ? ca1 : ca2);
            apb(1'b1, `OSCD_REG_RST, i);
            rchk("cnt cleared", (i == 1) ? `OSCD_REG_CNT1 : `OSCD_REG_CNT2, 32'h0);
            chk("alarm cleared", 32'h0, (i == 1) ? ca1 : ca2);
        end
        $display("reset and corrupt test done");
        for (i = 1; i < 8; i = i + 1) begin
            sym(`OSCD_CTRL_RESET, i[2:0], cond(i), i[3:0]);
            sym(`OSCD_CTRL_RESET, i[2:0], 11'h000, `OSCD_SYM_NONE);
        end
        sym(32'h0, `OSCD_SEL_HEATER, 11'h0E0, `OSCD_SYM_NONE);
        apb(1'b1, `OSCD_REG_CTRL, `OSCD_CTRL_RESET | 32'h300);
        for (i = 0; i < 4; i = i + 1) begin
            pr = prio(i);
            p <= pr[13:3];
            wt(12);
            chk("sec priority", pr[2:0], ssrc);
        end
        $display("status display test done");
        code_try(16'h00A9, 1'b0, 40, 1'b0);
        code_try(`OSCD_ACCESS_CODE, 1'b0, KW + 20, 1'b1);
        rst_n <= 1'b0;
        wt(3);
        rst_n <= 1'b1;
        wt(1);
        chk("level after reset", 32'h0, adv);
        code_try(`OSCD_ACCESS_CODE, 1'b1, 10, 1'b1);
        $display("access level test done");
        wrap_up;
    end
endmodule // tb
